// File: rtl/adts_timing.sv
// Module: acquisition and analog-output timing pins with a small register port
//
// Summary of operation
// (R1) Scan clock rises whenever an A/D conversion begins.
// (R2) Scan clock pulses only with scanning enabled, otherwise stays low.
// (R3) Scan clock rests low, goes high about 4 us per conversion.
// (R4) Writing the strobe register emits one low pulse on the strobe pin.
// (R5) Strobe low pulse lasts between 200 and 500 ns.
// (R6) Low pulse on external convert input starts one conversion.
// (R7) Outside source holds convert low at least 50 ns.
// (R8) Converter enters hold soon after the convert falling edge.
// (R9) Outside source keeps convert high one conversion period between pulses.
// (R10) Interval counter drives convert pin unless external conversions are selected.
// (R11) Trigger falling edge starts sample and interval counters.
// (R12) Pretrigger: acquire uncounted until trigger; next edge starts sample counting.
// (R13) Pretrigger acquisition ends when sample counter reaches zero.
// (R14) First conversion comes within one sample interval after trigger.
// (R15) Outside trigger source keeps low and high phases at least 50 ns.
// (R16) External trigger ANDed with internal start; internal start needs line high.
// (R17) Gate low suppresses all conversions; high lets them proceed.
// (R18) DAC load input acts only with waveform enable set, alternate source off.
// (R19) DACs load on the falling edge of the DAC load input.
// (R20) DAC update completes within 100 ns of that falling edge; o_dac_update rises on the fourth clock edge after it, 120 to 160 ns.
// (R21) Every asynchronous input is synchronised before edge detection.
module adts_timing #(
  parameter int CNT_W = 16
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  // Register port
  input wire logic [adts_pkg::ADDR_W-1:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  // Connector inputs, active low
  input wire logic i_ext_convert_n,
  input wire logic i_ext_trigger_n,
  input wire logic i_ext_gate_n,
  input wire logic i_ext_dac_load_n,
  // Convert pin driven by the interval counter
  output logic o_convert_out,
  output logic o_convert_oe,
  // Connector outputs
  output logic o_scan_clock_out,
  output logic o_ext_strobe_n,
  // Converter and DAC control
  output logic o_conv_start,
  output logic o_dac_update,
  output logic o_acq_done
);

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Declarations
  adts_pkg::adts_bus_req_t req;
  adts_pkg::adts_ctrl_t ctrl_q;
  adts_pkg::adts_acq_state_t state_q;
  logic [CNT_W-1:0] interval_q;
  logic [CNT_W-1:0] count_q;
  logic [CNT_W-1:0] remain_q;
  logic [CNT_W-1:0] si_cnt_q;
  logic [adts_pkg::TIMER_W-1:0] scan_tmr_q;
  logic [adts_pkg::TIMER_W-1:0] strobe_tmr_q;
  logic [adts_pkg::NUM_IN-1:0] pins;
  logic [adts_pkg::NUM_IN-1:0] s1_q;
  logic [adts_pkg::NUM_IN-1:0] s2_q;
  logic [adts_pkg::NUM_IN-1:0] s3_q;
  logic [adts_pkg::NUM_IN-1:0] lvl_q;
  logic [adts_pkg::NUM_IN-1:0] fall;
  logic wr_cmd;
  logic arm_cmd;
  logic abort_cmd;
  logic int_start;
  logic trig_line_q;
  logic trig_fall;
  logic acquiring;
  logic si_run;
  logic si_tick;
  logic conv_req;
  logic conv_start;
  logic last_sample;
  logic [31:0] status;
  logic [31:0] rdata_d;

  assign req = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Input synchronisers: three stages, a change counts once stages two and three agree
  assign pins = {i_ext_dac_load_n, i_ext_gate_n, i_ext_trigger_n, i_ext_convert_n};

  // Stage chain, reset to the idle (high) level of the pulled-up lines
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      s1_q <= '1;
      s2_q <= '1;
      s3_q <= '1;
    end else begin
      s1_q <= pins; // R21
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Filtered levels and one falling-edge event per edge
  assign fall = lvl_q & ~s2_q & ~s3_q; // R21

  // A lane takes a new level only once stages two and three agree
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      lvl_q <= '1;
    end else begin
      lvl_q <= (s2_q & s3_q) | (lvl_q & (s2_q ^ s3_q)); // R21
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Register writes
  assign wr_cmd = req.wr && (req.addr == adts_pkg::REG_CMD);
  assign arm_cmd = wr_cmd && req.wdata[adts_pkg::CMD_ARM_BIT];
  assign abort_cmd = wr_cmd && req.wdata[adts_pkg::CMD_ABORT_BIT];
  assign int_start = wr_cmd && req.wdata[adts_pkg::CMD_START_BIT];

  // Control register
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ctrl_q <= adts_pkg::CTRL_RESET;
    end else if (req.wr && (req.addr == adts_pkg::REG_CTRL)) begin
      ctrl_q <= req.wdata[$bits(adts_pkg::adts_ctrl_t)-1:0];
    end
  end

  // Sample interval and sample count
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      interval_q <= CNT_W'(adts_pkg::INTERVAL_RESET);
      count_q <= CNT_W'(adts_pkg::COUNT_RESET);
    end else begin
      if (req.wr && (req.addr == adts_pkg::REG_INTERVAL)) begin
        interval_q <= req.wdata[CNT_W-1:0];
      end
      if (req.wr && (req.addr == adts_pkg::REG_COUNT)) begin
        count_q <= req.wdata[CNT_W-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Trigger: internal start acts only while the external line is high
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      trig_line_q <= 1'b1;
    end else begin
      trig_line_q <= lvl_q[adts_pkg::IN_TRIG] & ~int_start; // R16
    end
  end

  // A falling edge of the combined line is a trigger event
  assign trig_fall = trig_line_q & ~(lvl_q[adts_pkg::IN_TRIG] & ~int_start); // R16

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Acquisition sequencer
  assign acquiring = (state_q == adts_pkg::ACQ_PRE) || (state_q == adts_pkg::ACQ_POST);
  assign last_sample = (state_q == adts_pkg::ACQ_POST) && conv_start && (remain_q <= CNT_W'(1));

  // State transitions
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_q <= adts_pkg::ACQ_IDLE;
    end else if (abort_cmd) begin
      state_q <= adts_pkg::ACQ_IDLE;
    end else begin
      unique case (state_q)
        adts_pkg::ACQ_IDLE: begin
          if (arm_cmd) begin
            state_q <= adts_pkg::ACQ_ARMED;
          end
        end
        adts_pkg::ACQ_ARMED: begin
          if (trig_fall && ctrl_q.pretrigger_mode) begin
            state_q <= adts_pkg::ACQ_PRE; // R12
          end else if (trig_fall) begin
            state_q <= adts_pkg::ACQ_POST; // R11
          end
        end
        adts_pkg::ACQ_PRE: begin
          if (trig_fall) begin
            state_q <= adts_pkg::ACQ_POST; // R12
          end
        end
        adts_pkg::ACQ_POST: begin
          if (last_sample) begin
            state_q <= adts_pkg::ACQ_IDLE; // R13
          end
        end
      endcase
    end
  end

  // Sample counter: loaded when counting starts, one decrement per conversion in the post-trigger state
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      remain_q <= '0;
    end else if (trig_fall && (state_q != adts_pkg::ACQ_POST) && (state_q != adts_pkg::ACQ_IDLE)
                 && !(state_q == adts_pkg::ACQ_ARMED && ctrl_q.pretrigger_mode)) begin
      remain_q <= count_q; // R11
    end else if (conv_start && (state_q == adts_pkg::ACQ_POST) && (remain_q != '0)) begin
      remain_q <= remain_q - CNT_W'(1); // R13
    end
  end

  // Done pulse at the end of a sequence
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_acq_done <= 1'b0;
    end else begin
      o_acq_done <= last_sample;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Sample-interval counter, restarted by the trigger so the first tick lands in one interval
  assign si_run = acquiring && !ctrl_q.ext_convert_mode;
  assign si_tick = si_run && (si_cnt_q <= CNT_W'(1)); // R14

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      si_cnt_q <= '0;
    end else if (trig_fall && (state_q == adts_pkg::ACQ_ARMED)) begin
      si_cnt_q <= interval_q; // R11
    end else if (si_tick) begin
      si_cnt_q <= interval_q; // R14
    end else if (si_run) begin
      si_cnt_q <= si_cnt_q - CNT_W'(1);
    end
  end

  // Counter output on the convert pin, released when external pulses take over
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_convert_out <= 1'b1;
      o_convert_oe <= 1'b0;
    end else begin
      o_convert_out <= ~si_tick; // R10
      o_convert_oe <= ~ctrl_q.ext_convert_mode; // R10
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Conversion start: source by mode, suppressed while the gate input is low
  assign conv_req = ctrl_q.ext_convert_mode ? fall[adts_pkg::IN_CONV] : si_tick; // R6
  assign conv_start = conv_req && acquiring && lvl_q[adts_pkg::IN_GATE]; // R17

  // Hold command to the converter, one cycle after the synchronised edge
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_conv_start <= 1'b0;
    end else begin
      o_conv_start <= conv_start; // R8
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Scan clock: high for a fixed time from each conversion start while scanning
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      scan_tmr_q <= '0;
    end else if (!ctrl_q.scan_enable) begin
      scan_tmr_q <= '0; // R2
    end else if (conv_start) begin
      scan_tmr_q <= adts_pkg::SCAN_CYCLES; // R1 R3
    end else if (scan_tmr_q != '0) begin
      scan_tmr_q <= scan_tmr_q - adts_pkg::TIMER_W'(1);
    end
  end

  // Registered pin; a new start during a pulse forces a low cycle so each start shows an edge
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_scan_clock_out <= 1'b0;
    end else begin
      o_scan_clock_out <= ctrl_q.scan_enable && (scan_tmr_q != '0) && !conv_start; // R1 R2 R3
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Strobe: a write to the strobe register starts one low pulse
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      strobe_tmr_q <= '0;
    end else if (req.wr && (req.addr == adts_pkg::REG_STROBE)) begin
      strobe_tmr_q <= adts_pkg::STROBE_CYCLES; // R4 R5
    end else if (strobe_tmr_q != '0) begin
      strobe_tmr_q <= strobe_tmr_q - adts_pkg::TIMER_W'(1);
    end
  end

  // Strobe pin, low while the timer runs
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_ext_strobe_n <= 1'b1;
    end else begin
      o_ext_strobe_n <= (strobe_tmr_q == '0); // R4
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  // DAC update from the external load input
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_dac_update <= 1'b0;
    end else begin
      o_dac_update <= fall[adts_pkg::IN_DAC] && ctrl_q.waveform_gen_enable // R19 R20
                      && !ctrl_q.alt_update_source; // R18
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Read path: data stand in the cycle after the read strobe, unmapped reads return zero
  always_comb begin
    status = '0;
    status[adts_pkg::ST_REMAIN_LSB +: CNT_W] = remain_q;
    status[adts_pkg::ST_STATE_LSB +: 2] = state_q;
    status[adts_pkg::ST_GATE_BIT] = lvl_q[adts_pkg::IN_GATE];
    status[adts_pkg::ST_TRIG_BIT] = lvl_q[adts_pkg::IN_TRIG];
    status[adts_pkg::ST_SCAN_BIT] = o_scan_clock_out;
    status[adts_pkg::ST_STROBE_BIT] = ~o_ext_strobe_n;
  end

  // Address decode for reads
  always_comb begin
    rdata_d = '0;
    unique case (req.addr)
      adts_pkg::REG_CTRL: rdata_d[$bits(adts_pkg::adts_ctrl_t)-1:0] = ctrl_q;
      adts_pkg::REG_INTERVAL: rdata_d[CNT_W-1:0] = interval_q;
      adts_pkg::REG_COUNT: rdata_d[CNT_W-1:0] = count_q;
      adts_pkg::REG_STATUS: rdata_d = status;
      default: rdata_d = '0;
    endcase
  end

  // Read data register, zero outside the answer cycle
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_rdata <= '0;
    end else if (req.rd) begin
      o_rdata <= rdata_d;
    end else begin
      o_rdata <= '0;
    end
  end

endmodule : adts_timing

// File: shared/adts_pkg.sv
// Package: register map, field layouts and timing constants of the acquisition timing block
package adts_pkg;

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Register offsets (byte addresses, one 32-bit word each)
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] REG_CMD = 8'h04;
  localparam logic [ADDR_W-1:0] REG_INTERVAL = 8'h08;
  localparam logic [ADDR_W-1:0] REG_COUNT = 8'h0C;
  localparam logic [ADDR_W-1:0] REG_STROBE = 8'h10;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h14;

  // Field positions of the command register (write-only, self clearing)
  localparam int CMD_ARM_BIT = 0;
  localparam int CMD_START_BIT = 1;
  localparam int CMD_ABORT_BIT = 2;

  // Field positions of the status register
  localparam int ST_REMAIN_LSB = 0;
  localparam int ST_STATE_LSB = 16;
  localparam int ST_GATE_BIT = 18;
  localparam int ST_TRIG_BIT = 19;
  localparam int ST_SCAN_BIT = 20;
  localparam int ST_STROBE_BIT = 21;

  // Reset values
  localparam logic [4:0] CTRL_RESET = 5'h00;
  localparam logic [15:0] INTERVAL_RESET = 16'h0019;
  localparam logic [15:0] COUNT_RESET = 16'h0001;

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int SCAN_HIGH_NS = 4000;
  localparam int STROBE_MIN_NS = 200;
  localparam int SCAN_CYCLES_I = SCAN_HIGH_NS / CLK_PERIOD_NS;
  localparam int STROBE_CYCLES_I = (STROBE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TIMER_W = 8;
  localparam logic [TIMER_W-1:0] SCAN_CYCLES = TIMER_W'(SCAN_CYCLES_I);
  localparam logic [TIMER_W-1:0] STROBE_CYCLES = TIMER_W'(STROBE_CYCLES_I);

  // Synchronised input lanes
  localparam int NUM_IN = 4;
  localparam int IN_CONV = 0;
  localparam int IN_TRIG = 1;
  localparam int IN_GATE = 2;
  localparam int IN_DAC = 3;

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Types
  typedef struct packed {
    logic alt_update_source;
    logic waveform_gen_enable;
    logic pretrigger_mode;
    logic ext_convert_mode;
    logic scan_enable;
  } adts_ctrl_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } adts_bus_req_t;

  typedef enum logic [1:0] {
    ACQ_IDLE,
    ACQ_ARMED,
    ACQ_PRE,
    ACQ_POST
  } adts_acq_state_t;

endpackage : adts_pkg

// File: sim/adts_far_model.sv
// Far-side sources: convert, trigger, gate and DAC load drivers
module adts_far_model (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  // Convert pin drive from the block
  input wire logic i_convert_out,
  input wire logic i_convert_oe,
  // Source levels and one-cycle pulse requests, one bit per line
  input wire logic [3:0] i_level_n,
  input wire logic [3:0] i_pulse,
  // Lines toward the block
  output logic o_ext_convert_n,
  output logic o_ext_trigger_n,
  output logic o_ext_gate_n,
  output logic o_ext_dac_load_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] run_q [4];
  logic [3:0] line_n;
  // Each pulse request holds its line low for three cycles
  always @(posedge i_core_clk or negedge i_reset_n) begin
    for (int ch = 0; ch < 4; ch++) begin
      if (!i_reset_n) begin
        run_q[ch] <= 2'h0;
      end else if (i_pulse[ch]) begin
        run_q[ch] <= 2'h3;
      end else if (run_q[ch] != 2'h0) begin
        run_q[ch] <= run_q[ch] - 2'h1;
      end
    end
  end
  // Pulled-up lines: high unless a source holds them low
  always_comb begin
    for (int ch = 0; ch < 4; ch++) begin
      line_n[ch] = i_level_n[ch] && (run_q[ch] == 2'h0);
    end
  end
  // Convert pin shows the block's drive while enabled
  assign o_ext_convert_n = i_convert_oe ? i_convert_out : line_n[0];
  assign o_ext_trigger_n = line_n[1];
  assign o_ext_gate_n = line_n[2];
  assign o_ext_dac_load_n = line_n[3];
endmodule : adts_far_model

// File: sim/adts_timing_asserts.sv
// Checker: pin timing relations of the acquisition timing block
module adts_timing_asserts (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  // Register port
  input wire logic [adts_pkg::ADDR_W-1:0] i_addr,
  input wire logic i_wr,
  // Connector inputs
  input wire logic i_ext_convert_n,
  input wire logic i_ext_gate_n,
  input wire logic i_ext_dac_load_n,
  // Outputs
  input wire logic o_convert_out,
  input wire logic o_scan_clock_out,
  input wire logic o_ext_strobe_n,
  input wire logic o_conv_start,
  input wire logic o_dac_update,
  input wire logic o_acq_done
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] scan_q;
  logic [7:0] low_q;
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_reset_n);
  // Run lengths of scan high and strobe low
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      scan_q <= 8'h00;
      low_q <= 8'h00;
    end else begin
      scan_q <= o_scan_clock_out ? scan_q + 8'h01 : 8'h00;
      low_q <= !o_ext_strobe_n ? low_q + 8'h01 : 8'h00;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  a_scan_after_start: assert property ($rose(o_scan_clock_out) |-> $past(o_conv_start))
    else $error("scan clock rose without a conversion start");
  a_scan_width: assert property (scan_q <= 8'h64)
    else $error("scan clock high too long");
  a_strobe_start: assert property ((i_wr && i_addr == adts_pkg::REG_STROBE) |-> ##2 !o_ext_strobe_n)
    else $error("strobe did not fall after its write");
  a_strobe_width: assert property ($rose(o_ext_strobe_n) |-> low_q == 8'h05)
    else $error("strobe low width wrong");
  a_conv_cause: assert property (o_conv_start |-> !o_convert_out || !$past(i_ext_convert_n, 3))
    else $error("conversion start without a cause");
  a_gate_blocks: assert property (o_conv_start |-> $past(i_ext_gate_n, 5))
    else $error("conversion while gate low");
  a_dac_edge: assert property (o_dac_update |-> !$past(i_ext_dac_load_n, 4) && $past(i_ext_dac_load_n, 5))
    else $error("dac update not tied to load fall");
  a_done_conv: assert property (o_acq_done |-> o_conv_start)
    else $error("done without final conversion");
  a_tick_pulse: assert property ($fell(o_convert_out) |=> o_convert_out)
    else $error("interval tick longer than one cycle");
  c_done: cover property (o_acq_done);
  c_dac: cover property (o_dac_update);
  c_strobe: cover property ($fell(o_ext_strobe_n));
endmodule : adts_timing_asserts

bind adts_timing adts_timing_asserts u_chk (.i_core_clk(i_core_clk), .i_reset_n(i_reset_n),
  .i_addr(i_addr), .i_wr(i_wr), .i_ext_convert_n(i_ext_convert_n), .i_ext_gate_n(i_ext_gate_n),
  .i_ext_dac_load_n(i_ext_dac_load_n), .o_convert_out(o_convert_out),
  .o_scan_clock_out(o_scan_clock_out), .o_ext_strobe_n(o_ext_strobe_n),
  .o_conv_start(o_conv_start), .o_dac_update(o_dac_update), .o_acq_done(o_acq_done));

// File: sim/tb_acq_and_dac_timing_signals.sv
// Testbench: register port, pin pulses and acquisition sequences
module tb_acq_and_dac_timing_signals;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_core_clk, i_reset_n, i_wr, i_rd, clr;
  logic [adts_pkg::ADDR_W-1:0] i_addr;
  logic [31:0] i_wdata, o_rdata, rd, n_conv, n_dac, n_done, n_scan, n_low, n_tick;
  logic [3:0] lvl_n, pls;
  logic cv_n, tg_n, gt_n, dl_n, o_convert_out, o_convert_oe, o_scan_clock_out;
  logic o_ext_strobe_n, o_conv_start, o_dac_update, o_acq_done;
  int err_count;
  int n_compared;
  logic [7:0] ra [6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h18};
  logic [31:0] rv [6] = '{32'h0, 32'h0, 32'h19, 32'h1, 32'h0, 32'h0};
  initial begin
    i_core_clk = 1'b0;
    forever #20 i_core_clk = ~i_core_clk;
  end
  adts_timing dut (.i_core_clk(i_core_clk), .i_reset_n(i_reset_n), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_ext_convert_n(cv_n),
    .i_ext_trigger_n(tg_n), .i_ext_gate_n(gt_n), .i_ext_dac_load_n(dl_n),
    .o_convert_out(o_convert_out), .o_convert_oe(o_convert_oe),
    .o_scan_clock_out(o_scan_clock_out), .o_ext_strobe_n(o_ext_strobe_n),
    .o_conv_start(o_conv_start), .o_dac_update(o_dac_update), .o_acq_done(o_acq_done));
  adts_far_model far (.i_core_clk(i_core_clk), .i_reset_n(i_reset_n),
    .i_convert_out(o_convert_out), .i_convert_oe(o_convert_oe), .i_level_n(lvl_n),
    .i_pulse(pls), .o_ext_convert_n(cv_n), .o_ext_trigger_n(tg_n),
    .o_ext_gate_n(gt_n), .o_ext_dac_load_n(dl_n));
  // Event tallies since the last clear
  always @(posedge i_core_clk) begin
    n_conv <= clr ? 32'h0 : n_conv + {31'h0, o_conv_start};
    n_dac <= clr ? 32'h0 : n_dac + {31'h0, o_dac_update};
    n_done <= clr ? 32'h0 : n_done + {31'h0, o_acq_done};
    n_scan <= clr ? 32'h0 : n_scan + {31'h0, o_scan_clock_out};
    n_low <= clr ? 32'h0 : n_low + {31'h0, !o_ext_strobe_n};
    n_tick <= clr ? 32'h0 : n_tick + {31'h0, !o_convert_out};
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_core_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_core_clk);
    i_wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a);
    @(posedge i_core_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_core_clk);
    i_rd <= 1'b0;
    #1 rd = o_rdata;
  endtask : rd_reg
  // Set one source level just after an edge
  task automatic set_line(input int ch, input logic lvl);
    @(posedge i_core_clk);
    lvl_n[ch] <= lvl;
  endtask : set_line
  // One three-cycle low pulse, then the line rests high for eight cycles or more
  task automatic pulse(input int ch);
    @(posedge i_core_clk);
    pls[ch] <= 1'b1;
    @(posedge i_core_clk);
    pls[ch] <= 1'b0;
    repeat (11) @(posedge i_core_clk);
    #1;
  endtask : pulse
  task automatic wait_n(input int n);
    repeat (n) @(posedge i_core_clk);
    #1;
  endtask : wait_n
  task automatic clear();
    @(posedge i_core_clk);
    clr <= 1'b1;
    @(posedge i_core_clk);
    clr <= 1'b0;
  endtask : clear
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic finish_test();
    if (err_count == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : finish_test
  // Watchdog
  initial begin
    #400000;
    err_count++;
    finish_test();
  end
  // Main sequence
  initial begin
    i_reset_n = 1'b0;
    i_addr = 8'h00;
    i_wdata = 32'h0;
    i_wr = 1'b0;
    i_rd = 1'b0;
    clr = 1'b1;
    lvl_n = 4'hF;
    pls = 4'h0;
    err_count = 0;
    n_compared = 0;
    repeat (16) @(posedge i_core_clk);
    i_reset_n <= 1'b1;
    for (int k = 0; k < 6; k++) begin
      rd_reg(ra[k]);
      chk("reset_value", rv[k], rd);
    end
    clear();
    wr_reg(adts_pkg::REG_STROBE, 32'h0);
    #1 chk("strobe_c1", 32'h1, {31'h0, o_ext_strobe_n});
    wait_n(10);
    chk("strobe_low", 32'h5, n_low);
    wr_reg(adts_pkg::REG_INTERVAL, 32'h78);
    wr_reg(adts_pkg::REG_COUNT, 32'h2);
    for (int se = 1; se >= 0; se--) begin
      wr_reg(adts_pkg::REG_CTRL, 32'(se));
      clear();
      wr_reg(adts_pkg::REG_CMD, 32'h1);
      wr_reg(adts_pkg::REG_CMD, 32'h2);
      wait_n(126);
      chk("first_conv", 32'h1, n_conv);
      wait_n(274);
      chk("conv_count", 32'h2, n_conv);
      chk("tick_count", 32'h2, n_tick);
      chk("done_count", 32'h1, n_done);
      chk("scan_band", 32'h1,
          {31'h0, n_scan >= 32'(198 * se) && n_scan <= 32'(200 * se)});
    end
    wr_reg(adts_pkg::REG_INTERVAL, 32'hFF);
    set_line(1, 1'b0);
    wait_n(4);
    wr_reg(adts_pkg::REG_CMD, 32'h1);
    wr_reg(adts_pkg::REG_CMD, 32'h2);
    set_line(1, 1'b1);
    rd_reg(adts_pkg::REG_STATUS);
    chk("state_armed", 32'h1, rd[17:16]);
    pulse(1);
    rd_reg(adts_pkg::REG_STATUS);
    chk("state_post", 32'h3, rd[17:16]);
    chk("remain", 32'h2, rd[15:0]);
    wr_reg(adts_pkg::REG_CMD, 32'h4);
    wr_reg(adts_pkg::REG_CTRL, 32'h6);
    wait_n(2);
    chk("oe_ext", 32'h0, {31'h0, o_convert_oe});
    clear();
    wr_reg(adts_pkg::REG_CMD, 32'h1);
    pulse(1);
    set_line(2, 1'b0);
    wait_n(4);
    pulse(0);
    set_line(2, 1'b1);
    wait_n(4);
    pulse(0);
    pulse(0);
    rd_reg(adts_pkg::REG_STATUS);
    chk("state_pre", 32'h2, rd[17:16]);
    chk("pre_convs", 32'h2, n_conv);
    pulse(1);
    pulse(0);
    pulse(0);
    chk("post_done", 32'h1, n_done);
    chk("post_convs", 32'h4, n_conv);
    for (int i = 0; i < 4; i++) begin
      wr_reg(adts_pkg::REG_CTRL, 32'(i * 8));
      clear();
      pulse(3);
      chk("dac_update", 32'(i == 1), n_dac);
    end
    chk("oe_int", 32'h1, {31'h0, o_convert_oe});
    finish_test();
  end
endmodule : tb_acq_and_dac_timing_signals
